/* dv/msc_regs_checker.sv */
// assertions for the misc system config register bank
// assumes binding into msc_regs, one clock, async low reset
module msc_regs_checker (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// register bus
	input wire msc_pkg::msc_avs_req_s avs_req,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// core and outputs
	input wire logic [11:0] pc_current,
	input wire logic pc_high_keep_flag,
	input wire logic [4:0] fast_osc_fine_tune,
	input wire logic regulator_pin_output_enable,
	input wire logic [1:0] rom_read_delay_ctrl,
	input wire logic [4:0] rom_read_delay_ns
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] idx;
	logic [3:0] pc_up;
	logic wr_ok;
	assign idx = avs_req.address[11:2];
	assign pc_up = pc_current[11:8];
	assign wr_ok = avs_req.write && avs_req.byteenable[0] && !avs_waitrequest;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_keep_code_set: assert property (
		wr_ok && idx == msc_pkg::IDX_PC_HIGH && avs_req.writedata[7:0] == 8'h1c
		|=> pc_high_keep_flag) else $error("keep flag not set");
	a_keep_other_clear: assert property (
		wr_ok && idx == msc_pkg::IDX_PC_HIGH && avs_req.writedata[7:0] != 8'h1c
		|=> !pc_high_keep_flag) else $error("keep flag not cleared");
	// pc sampled at the edge that took the request
	a_pc_readback: assert property (
		!avs_waitrequest && $past(avs_req.read) && $past(idx) == 10'h10c
		|-> avs_readdata == {28'h0, $past(pc_up)}) else $error("pc readback");
	a_pin_route: assert property (
		wr_ok && idx == msc_pkg::IDX_REG_PIN
		|=> regulator_pin_output_enable == $past(avs_req.writedata[0]))
		else $error("regulator enable");
	a_delay_decode: assert property (
		rom_read_delay_ns == 5'h14 - {1'h0, rom_read_delay_ctrl, 2'h0})
		else $error("delay decode");
	a_fine_write: assert property (
		wr_ok && idx == msc_pkg::IDX_FINE_TUNE
		|=> fast_osc_fine_tune == $past(avs_req.writedata[4:0]))
		else $error("fine tune write");
	a_fine_hold: assert property (
		!$stable(fast_osc_fine_tune) |-> $past(wr_ok && idx == 10'h114))
		else $error("fine tune changed");
	a_upper_zero: assert property (
		avs_readdata[31:8] == 24'h0) else $error("upper read bits");
	a_one_wait: assert property (
		(avs_req.read || avs_req.write) && avs_waitrequest
		|=> !avs_waitrequest ##1 avs_waitrequest) else $error("wait state");
	c_keep_set: cover property (pc_high_keep_flag);
	c_read_done: cover property (avs_req.read && !avs_waitrequest);
	c_delay_min: cover property (rom_read_delay_ctrl == 2'h3);
endmodule // msc_regs_checker

bind msc_regs msc_regs_checker msc_regs_checker_i (
	.ref_clk(ref_clk),
	.rstn(rstn),
	.avs_req(avs_req),
	.avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest),
	.pc_current(pc_current),
	.pc_high_keep_flag(pc_high_keep_flag),
	.fast_osc_fine_tune(fast_osc_fine_tune),
	.regulator_pin_output_enable(regulator_pin_output_enable),
	.rom_read_delay_ctrl(rom_read_delay_ctrl),
	.rom_read_delay_ns(rom_read_delay_ns)
);

/* dv/tb_top.sv */
// self-checking bench for the misc system config register bank
// assumes the checker is compiled and bound beforehand
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk;
	logic rstn;
	msc_pkg::msc_avs_req_s avs_req;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	msc_pkg::msc_cfg_s cfg;
	logic [11:0] pc_current;
	logic pc_high_keep_flag;
	logic [4:0] bandgap_trim;
	logic [6:0] fast_osc_trim;
	logic [4:0] fast_osc_fine_tune;
	logic regulator_pin_output_enable;
	logic [1:0] rom_read_delay_ctrl;
	logic [4:0] rom_read_delay_ns;
	logic [31:0] expq[$];
	logic [7:0] mem [80];
	logic [7:0] d;
	logic [11:0] p;
	int miscompares = 0;
	int cmp_count = 0;
	int cycles = 0;
	integer seed;

	msc_regs msc_regs_i (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.avs_req(avs_req),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.cfg(cfg),
		.pc_current(pc_current),
		.pc_high_keep_flag(pc_high_keep_flag),
		.bandgap_trim(bandgap_trim),
		.fast_osc_trim(fast_osc_trim),
		.fast_osc_fine_tune(fast_osc_fine_tune),
		.regulator_pin_output_enable(regulator_pin_output_enable),
		.rom_read_delay_ctrl(rom_read_delay_ctrl),
		.rom_read_delay_ns(rom_read_delay_ns)
	);

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// ------------------------------------------------------------
	// report and compare
	// ------------------------------------------------------------
	task automatic summarize();
		if (miscompares == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t read %h exp %h", $time, g, e);
		end
	endtask

	task automatic cmp_out(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t port %h exp %h", $time, g, e);
		end
	endtask

	// hang guard, run needs well under a thousand cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			summarize();
		end
	end

	// read data stand only in the cycle waitrequest is low
	always @(posedge ref_clk) begin
		if (rstn === 1'b1 && avs_waitrequest === 1'b0 && avs_req.read === 1'b1) begin
			if (expq.size() == 0)
				cmp_rd(avs_readdata, 32'hdeadbeef);
			else
				cmp_rd(avs_readdata, expq.pop_front());
		end
	end

	// ------------------------------------------------------------
	// bus tasks, called just after a rising edge
	// ------------------------------------------------------------
	task automatic bus(input logic rd, input logic [11:0] a,
		input logic [7:0] v, input logic be, input logic hold);
		avs_req <= '{rd, !rd, a, {24'h0, v}, {3'h0, be}};
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		// an idle edge keeps release and next request apart
		if (!hold) begin
			avs_req <= '0;
			@(posedge ref_clk);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		bus(1'b0, a, v, 1'b1, 1'b0);
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] e,
		input logic hold);
		expq.push_back({24'h0, e});
		bus(1'b1, a, 8'h00, 1'b1, hold);
	endtask

	task automatic chk_rst();
		cmp_out({7'h0, pc_high_keep_flag}, 8'h00);
		cmp_out({3'h0, bandgap_trim}, {3'h0, cfg.bandgap_trim});
		cmp_out({1'h0, fast_osc_trim}, {1'h0, cfg.fast_osc_trim});
		cmp_out({3'h0, fast_osc_fine_tune}, 8'h00);
		cmp_out({7'h0, regulator_pin_output_enable}, 8'h00);
		cmp_out({6'h0, rom_read_delay_ctrl}, 8'h00);
		cmp_out({3'h0, rom_read_delay_ns}, 8'h14);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		seed = 32'he0184346;
		avs_req = '0;
		rstn = 1'b0;
		cfg = 20'($random(seed));
		pc_current = 12'($random(seed));
		repeat (16) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (2) @(posedge ref_clk);
		chk_rst();
		rd(12'h438, {3'h0, cfg.bandgap_trim}, 1'b1);
		rd(12'h43c, {1'h0, cfg.fast_osc_trim}, 1'b1);
		rd(12'h444, cfg.alt_bandgap_trim_value, 1'b1);
		rd(12'h430, {4'h0, pc_current[11:8]}, 1'b1);
		rd(12'h448, 8'h00, 1'b1);
		rd(12'h44c, 8'h00, 1'b1);
		rd(12'h450, 8'h00, 1'b0);
		// keep flag set and clear, random other codes
		for (int i = 0; i < 6; i++) begin
			d = (i % 2 == 0) ? 8'h1c : 8'($random(seed));
			if (d == 8'h1c && i % 2 == 1)
				d = 8'h1d;
			wr(12'h430, d);
			cmp_out({7'h0, pc_high_keep_flag}, {7'h0, d == 8'h1c});
		end
		wr(12'h430, 8'h1c);
		bus(1'b0, 12'h430, 8'h00, 1'b0, 1'b0);
		cmp_out({7'h0, pc_high_keep_flag}, 8'h01);
		p = 12'($random(seed));
		pc_current <= p;
		rd(12'h430, {4'h0, p[11:8]}, 1'b0);
		wr(12'h430, 8'h00);
		cmp_out({7'h0, pc_high_keep_flag}, 8'h00);
		wr(12'h448, 8'hff);
		cmp_out({7'h0, regulator_pin_output_enable}, 8'h01);
		rd(12'h448, 8'h01, 1'b0);
		wr(12'h448, 8'hfe);
		cmp_out({7'h0, regulator_pin_output_enable}, 8'h00);
		// one clock here; delay writes stand for slow-clock writes
		for (int c = 0; c < 4; c++) begin
			wr(12'h44c, {6'h3f, 2'(c)});
			cmp_out({6'h0, rom_read_delay_ctrl}, 8'(c));
			cmp_out({3'h0, rom_read_delay_ns}, 8'(20 - 4 * c));
			rd(12'h44c, 8'(c), 1'b0);
		end
		d = 8'($random(seed));
		wr(12'h450, d);
		cmp_out({3'h0, fast_osc_fine_tune}, {3'h0, d[4:0]});
		rd(12'h450, {3'h0, d[4:0]}, 1'b0);
		// read-only alt value, then copied into the writable trim
		wr(12'h444, ~cfg.alt_bandgap_trim_value);
		rd(12'h444, cfg.alt_bandgap_trim_value, 1'b0);
		wr(12'h438, cfg.alt_bandgap_trim_value);
		cmp_out({3'h0, bandgap_trim}, {3'h0, cfg.alt_bandgap_trim_value[4:0]});
		wr(12'h43c, 8'hff);
		cmp_out({1'h0, fast_osc_trim}, 8'h7f);
		// ram bank back to back, then unmapped places
		for (int i = 0; i < 80; i++) begin
			mem[i] = 8'($random(seed));
			bus(1'b0, 12'(12'h480 + 4 * i), mem[i], 1'b1, i < 79);
		end
		wr(12'h5c0, 8'haa);
		rd(12'h5c0, 8'h00, 1'b1);
		rd(12'h47c, 8'h00, 1'b1);
		for (int i = 0; i < 80; i++)
			rd(12'(12'h480 + 4 * i), mem[i], i < 79);
		// second reset in mid-run with everything set
		wr(12'h430, 8'h1c);
		// delay left at the shortest setting
		wr(12'h44c, 8'h03);
		wr(12'h448, 8'h01);
		rstn <= 1'b0;
		cfg <= 20'($random(seed));
		repeat (4) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (2) @(posedge ref_clk);
		chk_rst();
		summarize();
	end
endmodule // tb_top

/* rtl/msc_pkg.sv */
// constants, types and register map of the misc system config bank
// assumes a 32-bit avalon-mm slave port and one 100 mhz clock
package msc_pkg;

	// ----------------------------------------------------------------
	// bus geometry
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned BE_W = 4;
	localparam int unsigned IDX_W = 10;
	localparam int unsigned IDX_LSB = 2;
	localparam int unsigned IDX_MSB = 11;
	localparam int unsigned BYTE_W = 8;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [9:0] IDX_PC_HIGH = 10'h10c;
	localparam logic [9:0] IDX_BG_TRIM = 10'h10e;
	localparam logic [9:0] IDX_OSC_TRIM = 10'h10f;
	localparam logic [9:0] IDX_ALT_BG = 10'h111;
	localparam logic [9:0] IDX_REG_PIN = 10'h112;
	localparam logic [9:0] IDX_RD_DELAY = 10'h113;
	localparam logic [9:0] IDX_FINE_TUNE = 10'h114;
	localparam logic [9:0] IDX_RAM_FIRST = 10'h120;
	localparam logic [9:0] IDX_RAM_LAST = 10'h16f;

	// ----------------------------------------------------------------
	// ram bank
	// ----------------------------------------------------------------
	localparam int unsigned RAM_DEPTH = 80;
	localparam int unsigned RAM_AW = 7;

	// ----------------------------------------------------------------
	// field widths and positions
	// ----------------------------------------------------------------
	localparam int unsigned PC_W = 12;
	localparam int unsigned PC_UP_W = 4;
	localparam int unsigned PC_UP_MSB = 11;
	localparam int unsigned PC_UP_LSB = 8;
	localparam int unsigned BG_TRIM_W = 5;
	localparam int unsigned OSC_TRIM_W = 7;
	localparam int unsigned ALT_BG_W = 8;
	localparam int unsigned RD_DELAY_W = 2;
	localparam int unsigned FINE_TUNE_W = 5;
	localparam int unsigned DELAY_NS_W = 5;
	localparam int unsigned REG_PIN_BIT = 0;

	// ----------------------------------------------------------------
	// codes and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] PC_KEEP_CODE = 8'h1c;
	localparam logic PC_KEEP_RST = 1'b0;
	localparam logic REG_PIN_RST = 1'b0;
	localparam logic [1:0] RD_DELAY_RST = 2'h0;
	localparam logic [4:0] FINE_TUNE_RST = 5'h00;

	// read strobe delay in ns per setting
	localparam logic [1:0] RD_DELAY_20 = 2'h0;
	localparam logic [1:0] RD_DELAY_16 = 2'h1;
	localparam logic [1:0] RD_DELAY_12 = 2'h2;
	localparam logic [1:0] RD_DELAY_8 = 2'h3;
	localparam logic [4:0] RD_DELAY_NS_20 = 5'h14;
	localparam logic [4:0] RD_DELAY_NS_16 = 5'h10;
	localparam logic [4:0] RD_DELAY_NS_12 = 5'h0c;
	localparam logic [4:0] RD_DELAY_NS_8 = 5'h08;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ACK = 1'b1
	} msc_bus_state_e;

	typedef struct packed {
		logic read;
		logic write;
		logic [11:0] address;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} msc_avs_req_s;

	typedef struct packed {
		logic [4:0] bandgap_trim;
		logic [6:0] fast_osc_trim;
		logic [7:0] alt_bandgap_trim_value;
	} msc_cfg_s;

	typedef struct packed {
		msc_bus_state_e state;
		logic waitrequest;
		logic [31:0] readdata;
		logic cfg_done;
		logic pc_high_keep_flag;
		logic [4:0] bandgap_trim;
		logic [6:0] fast_osc_trim;
		logic [7:0] alt_bandgap_trim_value;
		logic regulator_pin_output_enable;
		logic [1:0] rom_read_delay_ctrl;
		logic [4:0] rom_read_delay_ns;
		logic [4:0] fast_osc_fine_tune;
	} msc_state_s;

endpackage : msc_pkg

/* rtl/msc_ram.sv */
// 80-byte general purpose data ram bank
// assumes the caller gives an in-range offset; no reset of contents
module msc_ram (
	// clock
	input wire logic ref_clk,
	// write side
	input wire logic wr_en,
	input wire logic [msc_pkg::RAM_AW-1:0] offset,
	input wire logic [msc_pkg::BYTE_W-1:0] wdata,
	// read side, combinational
	output logic [msc_pkg::BYTE_W-1:0] rdata
);

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	// contents are left undefined after reset, so no reset term
	logic [msc_pkg::BYTE_W-1:0] mem [msc_pkg::RAM_DEPTH];

	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			mem[offset] <= wdata;
		end
	end

	// caller registers the read, so an async read costs no timing
	assign rdata = mem[offset];

endmodule // msc_ram

/* rtl/msc_regs.sv */
// misc system config register bank with its 80-byte ram bank
// assumes avalon-mm master holds each request until waitrequest is low
// assumes cfg straps are stable when reset is released
//
// Decided for this implementation: the Avalon-MM slave port.

// --------------------------------------------------------------------
// register bank
// --------------------------------------------------------------------
module msc_regs (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// register bus
	input wire msc_pkg::msc_avs_req_s avs_req,
	output logic [msc_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	// configuration values
	input wire msc_pkg::msc_cfg_s cfg,
	// core program counter
	input wire logic [msc_pkg::PC_W-1:0] pc_current,
	output logic pc_high_keep_flag,
	// bandgap
	output logic [msc_pkg::BG_TRIM_W-1:0] bandgap_trim,
	// internal oscillator
	output logic [msc_pkg::OSC_TRIM_W-1:0] fast_osc_trim,
	output logic [msc_pkg::FINE_TUNE_W-1:0] fast_osc_fine_tune,
	// regulator pin
	output logic regulator_pin_output_enable,
	// program rom read strobe
	output logic [msc_pkg::RD_DELAY_W-1:0] rom_read_delay_ctrl,
	output logic [msc_pkg::DELAY_NS_W-1:0] rom_read_delay_ns
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	// one packed struct keeps reset and next state in step
	msc_pkg::msc_state_s st_reg;
	msc_pkg::msc_state_s st_next;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	// words that decode as fields; anything else in the ram window
	// is data, anything outside both is unmapped
	localparam int unsigned NUM_REGS = 7;
	localparam logic [msc_pkg::IDX_W-1:0] REG_MAP [NUM_REGS] = '{
		msc_pkg::IDX_PC_HIGH,
		msc_pkg::IDX_BG_TRIM,
		msc_pkg::IDX_OSC_TRIM,
		msc_pkg::IDX_ALT_BG,
		msc_pkg::IDX_REG_PIN,
		msc_pkg::IDX_RD_DELAY,
		msc_pkg::IDX_FINE_TUNE
	};

	logic [msc_pkg::IDX_W-1:0] idx;
	logic [msc_pkg::IDX_W-1:0] ram_off_full;
	logic [msc_pkg::RAM_AW-1:0] ram_off;
	logic [msc_pkg::BYTE_W-1:0] wbyte;
	logic [msc_pkg::BYTE_W-1:0] ram_rdata;
	logic in_ram;
	logic low_lane;
	logic wr_commit;
	logic ram_wr;
	logic bus_ack;
	logic req_any;
	logic [NUM_REGS-1:0] reg_hit;
	logic reg_mapped;
	logic ram_sel;

	// low two address bits are byte lanes inside one word
	assign idx = avs_req.address[msc_pkg::IDX_MSB:msc_pkg::IDX_LSB];
	assign in_ram = (idx >= msc_pkg::IDX_RAM_FIRST) &&
		(idx <= msc_pkg::IDX_RAM_LAST);
	assign ram_off_full = idx - msc_pkg::IDX_RAM_FIRST;
	assign ram_off = ram_off_full[msc_pkg::RAM_AW-1:0];
	assign wbyte = avs_req.writedata[msc_pkg::BYTE_W-1:0];

	// read and write never rise together; if both, the read and the write are both served
	assign req_any = avs_req.read || avs_req.write;

	// only byte lane 0 carries data; other lanes are unused bits
	assign low_lane = avs_req.byteenable[0];

	// a write takes effect on the edge where waitrequest is low
	assign bus_ack = (st_reg.state == msc_pkg::BUS_ACK);
	assign wr_commit = bus_ack && avs_req.write && low_lane;

	// ram write strobe, never on a register word
	assign ram_wr = wr_commit && ram_sel;

	// ----------------------------------------------------------------
	// register hit decode
	// ----------------------------------------------------------------
	// one compare per register word; the ram window and the
	// register words are disjoint today, the mask only guards
	// against a later remap that lets them overlap
	for (genvar k = 0; k < NUM_REGS; k++) begin : g_hit
		assign reg_hit[k] = (idx == REG_MAP[k]);
	end

	// words hitting neither read zero and drop writes
	assign reg_mapped = |reg_hit;
	assign ram_sel = in_ram && !reg_mapped;

	// ----------------------------------------------------------------
	// ram bank
	// ----------------------------------------------------------------
	// 80-byte data bank
	msc_ram u_ram (
		.ref_clk(ref_clk),
		.wr_en(ram_wr),
		.offset(ram_off),
		.wdata(wbyte),
		.rdata(ram_rdata)
	);

	// ----------------------------------------------------------------
	// delay lookup
	// ----------------------------------------------------------------
	// decoded at write time so the strobe timing sees a flop
	function automatic logic [msc_pkg::DELAY_NS_W-1:0] delay_ns(
		input logic [msc_pkg::RD_DELAY_W-1:0] sel
	);
		logic [msc_pkg::DELAY_NS_W-1:0] ns;
		ns = msc_pkg::RD_DELAY_NS_20;
		case (sel)
			msc_pkg::RD_DELAY_20: begin
				ns = msc_pkg::RD_DELAY_NS_20;
			end
			msc_pkg::RD_DELAY_16: begin
				ns = msc_pkg::RD_DELAY_NS_16;
			end
			msc_pkg::RD_DELAY_12: begin
				ns = msc_pkg::RD_DELAY_NS_12;
			end
			msc_pkg::RD_DELAY_8: begin
				ns = msc_pkg::RD_DELAY_NS_8;
			end
			default: begin
				ns = msc_pkg::RD_DELAY_NS_20;
			end
		endcase
		return ns;
	endfunction

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	function automatic logic [msc_pkg::BYTE_W-1:0] read_byte(
		input logic [msc_pkg::IDX_W-1:0] ri,
		input msc_pkg::msc_state_s s,
		input logic [msc_pkg::PC_W-1:0] pc,
		input logic ram_hit,
		input logic [msc_pkg::BYTE_W-1:0] ram_byte
	);
		logic [msc_pkg::BYTE_W-1:0] v;
		v = '0;
		case (ri)
			msc_pkg::IDX_PC_HIGH: begin
				// live pc upper bits, upper nibble zero
				v[msc_pkg::PC_UP_W-1:0] =
					pc[msc_pkg::PC_UP_MSB:msc_pkg::PC_UP_LSB];
			end
			msc_pkg::IDX_BG_TRIM: begin
				v[msc_pkg::BG_TRIM_W-1:0] = s.bandgap_trim;
			end
			msc_pkg::IDX_OSC_TRIM: begin
				v[msc_pkg::OSC_TRIM_W-1:0] = s.fast_osc_trim;
			end
			msc_pkg::IDX_ALT_BG: begin
				v = s.alt_bandgap_trim_value;
			end
			msc_pkg::IDX_REG_PIN: begin
				v[msc_pkg::REG_PIN_BIT] =
					s.regulator_pin_output_enable;
			end
			msc_pkg::IDX_RD_DELAY: begin
				v[msc_pkg::RD_DELAY_W-1:0] = s.rom_read_delay_ctrl;
			end
			msc_pkg::IDX_FINE_TUNE: begin
				v[msc_pkg::FINE_TUNE_W-1:0] = s.fast_osc_fine_tune;
			end
			default: begin
				// ram window, anything else unmapped reads zero
				v = ram_hit ? ram_byte : '0;
			end
		endcase
		return v;
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_next = st_reg;

		// one-shot load of configured trims after reset release;
		// async reset cannot take a port value, so this is clocked
		if (!st_reg.cfg_done) begin
			st_next.cfg_done = 1'b1;
			st_next.bandgap_trim = cfg.bandgap_trim;
			st_next.fast_osc_trim = cfg.fast_osc_trim;
			// captured once, never written by software
			st_next.alt_bandgap_trim_value =
				cfg.alt_bandgap_trim_value;
		end

		case (st_reg.state)
			msc_pkg::BUS_IDLE: begin
				if (req_any) begin
					// answer one cycle after the request is seen
					// a request still high after its answer is new
					st_next.state = msc_pkg::BUS_ACK;
					st_next.waitrequest = 1'b0;
					st_next.readdata = '0;
					if (avs_req.read) begin
						st_next.readdata[msc_pkg::BYTE_W-1:0] =
							read_byte(idx, st_reg, pc_current,
							ram_sel, ram_rdata);
					end
				end
			end
			msc_pkg::BUS_ACK: begin
				st_next.state = msc_pkg::BUS_IDLE;
				st_next.waitrequest = 1'b1;
				st_next.readdata = '0;
				if (wr_commit) begin
					case (idx)
						msc_pkg::IDX_PC_HIGH: begin
							// select code keeps pc upper bits
							st_next.pc_high_keep_flag =
								(wbyte == msc_pkg::PC_KEEP_CODE);
						end
						msc_pkg::IDX_BG_TRIM: begin
							st_next.bandgap_trim =
								wbyte[msc_pkg::BG_TRIM_W-1:0];
						end
						msc_pkg::IDX_OSC_TRIM: begin
							st_next.fast_osc_trim =
								wbyte[msc_pkg::OSC_TRIM_W-1:0];
						end
						msc_pkg::IDX_ALT_BG: begin
							st_next.alt_bandgap_trim_value =
								st_reg.alt_bandgap_trim_value;
						end
						msc_pkg::IDX_REG_PIN: begin
							st_next.regulator_pin_output_enable =
								wbyte[msc_pkg::REG_PIN_BIT];
						end
						msc_pkg::IDX_RD_DELAY: begin
							st_next.rom_read_delay_ctrl =
								wbyte[msc_pkg::RD_DELAY_W-1:0];
							st_next.rom_read_delay_ns = delay_ns(
								wbyte[msc_pkg::RD_DELAY_W-1:0]);
						end
						msc_pkg::IDX_FINE_TUNE: begin
							st_next.fast_osc_fine_tune =
								wbyte[msc_pkg::FINE_TUNE_W-1:0];
						end
						default: begin
							st_next.pc_high_keep_flag =
								st_reg.pc_high_keep_flag;
						end
					endcase
				end
			end
			default: begin
				st_next.state = msc_pkg::BUS_IDLE;
				st_next.waitrequest = 1'b1;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	// trims sit at zero only until the first clocked cfg load
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_reg.state <= msc_pkg::BUS_IDLE;
			st_reg.waitrequest <= 1'b1;
			st_reg.readdata <= '0;
			st_reg.cfg_done <= 1'b0;
			st_reg.pc_high_keep_flag <= msc_pkg::PC_KEEP_RST;
			st_reg.bandgap_trim <= '0;
			st_reg.fast_osc_trim <= '0;
			st_reg.alt_bandgap_trim_value <= '0;
			st_reg.regulator_pin_output_enable <= msc_pkg::REG_PIN_RST;
			st_reg.rom_read_delay_ctrl <= msc_pkg::RD_DELAY_RST;
			st_reg.rom_read_delay_ns <= msc_pkg::RD_DELAY_NS_20;
			st_reg.fast_osc_fine_tune <= msc_pkg::FINE_TUNE_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// shortest delay is software's job; reset stays slowest
	// every output is a plain copy of st_reg, no logic after flops
	assign avs_readdata = st_reg.readdata;
	assign avs_waitrequest = st_reg.waitrequest;
	assign pc_high_keep_flag = st_reg.pc_high_keep_flag;
	assign bandgap_trim = st_reg.bandgap_trim;
	assign fast_osc_trim = st_reg.fast_osc_trim;
	assign fast_osc_fine_tune = st_reg.fast_osc_fine_tune;
	assign regulator_pin_output_enable =
		st_reg.regulator_pin_output_enable;
	assign rom_read_delay_ctrl = st_reg.rom_read_delay_ctrl;
	assign rom_read_delay_ns = st_reg.rom_read_delay_ns;

endmodule // msc_regs
